// ---- hw/wwdpe_pkg.sv ----
package wwdpe_pkg;

    // ========================================
    // Oscillator and timing
    // ========================================
    localparam int unsigned CLK_PERIOD_NS      = 50;
    // RC oscillator tick period, set by the external resistor
    localparam int unsigned OSC_PERIOD_NS      = 10000;
    localparam int unsigned OSC_DIV_CYCLES     = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Power-up delay and watchdog period counted in oscillator ticks
    localparam int unsigned POWERUP_DELAY_TICKS = 100;
    localparam int unsigned WDT_PERIOD_TICKS    = 300;
    localparam int unsigned SLEEP_TICKS         = 900;
    localparam int unsigned GOOD_CLEARS_NEEDED  = 3;
    localparam int unsigned TICK_W              = 16;

    // ========================================
    // Window split and states
    // ========================================
    typedef enum logic [0:0] {
        WWDPE_SPLIT_67_33,
        WWDPE_SPLIT_33_67
    } wwdpe_split_e;

    typedef enum logic [2:0] {
        WWDPE_MONITOR_LOW,
        WWDPE_POWERUP,
        WWDPE_CLOSED,
        WWDPE_OPEN,
        WWDPE_SLEEP
    } wwdpe_state_e;

endpackage

// ---- hw/wwdpe_tick_gen.sv ----
`timescale 1ns/1ps

// ========================================
// Oscillator time base
// ========================================
module wwdpe_tick_gen #(
    parameter int unsigned DIV = wwdpe_pkg::OSC_DIV_CYCLES
) (
    input  wire logic core_clk,
    input  wire logic rst,
    output logic      tick
);
    logic [15:0] divCount;
    wire         wrapNow = (divCount == 16'(DIV - 1));

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            divCount <= 16'h0000;
            tick     <= 1'b0;
        end
        else
        begin
            divCount <= wrapNow ? 16'h0000 : divCount + 16'h0001;
            tick     <= wrapNow;
        end
    end
endmodule

// ---- hw/wwdpe_watchdog.sv ----
`timescale 1ns/1ps

module wwdpe_watchdog #(
    parameter int unsigned  OSC_DIV      = wwdpe_pkg::OSC_DIV_CYCLES,
    parameter int unsigned  POWERUP_TICKS = wwdpe_pkg::POWERUP_DELAY_TICKS,
    parameter int unsigned  PERIOD_TICKS = wwdpe_pkg::WDT_PERIOD_TICKS,
    parameter int unsigned  SLEEP_LIMIT  = wwdpe_pkg::SLEEP_TICKS,
    parameter bit           SPLIT_33_67  = 1'b0,
    parameter bit           HAS_SLEEP    = 1'b0
) (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic monitor_in,
    input  wire logic wdt_clear_in,
    output logic      sysRstOut,
    output logic      sysRstOe,
    output logic      enable_n,
    output logic      sleepActive
);
    localparam int unsigned CLOSED_TICKS = SPLIT_33_67 ? PERIOD_TICKS / 3
                                                       : (PERIOD_TICKS * 2) / 3;
    // Open part is whatever the closed part leaves of the period
    localparam int unsigned OPEN_TICKS   = PERIOD_TICKS - CLOSED_TICKS;

    // ========================================
    // Time base and clear edge
    // ========================================
    logic tick;

    wwdpe_tick_gen #(
        .DIV (OSC_DIV)
    ) u_tick (
        .core_clk (core_clk),
        .rst      (rst),
        .tick     (tick)
    );

    logic clearMeta;
    logic clearSync;
    logic clearLast;
    logic monMeta;
    logic monSync;
    wire  clearEdge = clearSync & ~clearLast;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            clearMeta <= 1'b0;
            clearSync <= 1'b0;
            clearLast <= 1'b0;
            monMeta   <= 1'b0;
            monSync   <= 1'b0;
        end
        else
        begin
            clearMeta <= wdt_clear_in;
            clearSync <= clearMeta;
            clearLast <= clearSync;
            monMeta   <= monitor_in;
            monSync   <= monMeta;
        end
    end

    // ========================================
    // Sequencer
    // ========================================
    wwdpe_pkg::wwdpe_state_e state;
    wwdpe_pkg::wwdpe_state_e next_state;
    logic [wwdpe_pkg::TICK_W-1:0] ticks;
    logic [wwdpe_pkg::TICK_W-1:0] idleTicks;
    logic [1:0]                   goodCount;
    logic                         enabled;

    wire powerupDone = tick && (ticks == wwdpe_pkg::TICK_W'(POWERUP_TICKS - 1));
    wire closedDone  = tick && (ticks == wwdpe_pkg::TICK_W'(CLOSED_TICKS - 1));
    // Ticks restart on entering the open part, so late means the open part ran out
    wire openLate    = tick && (ticks == wwdpe_pkg::TICK_W'(OPEN_TICKS - 1));
    wire earlyClear  = (state == wwdpe_pkg::WWDPE_CLOSED) && clearEdge;
    wire goodClear   = (state == wwdpe_pkg::WWDPE_OPEN) && clearEdge;
    wire sleepHit    = HAS_SLEEP && tick
                       && (idleTicks == wwdpe_pkg::TICK_W'(SLEEP_LIMIT - 1));
    wire wdtFault    = earlyClear || (state == wwdpe_pkg::WWDPE_OPEN && openLate && !clearEdge);

    always_comb
    begin
        next_state = state;
        case (state)
            wwdpe_pkg::WWDPE_MONITOR_LOW: if (monSync) next_state = wwdpe_pkg::WWDPE_POWERUP;
            wwdpe_pkg::WWDPE_POWERUP:     if (powerupDone) next_state = wwdpe_pkg::WWDPE_CLOSED;
            wwdpe_pkg::WWDPE_CLOSED:
                if (earlyClear) next_state = wwdpe_pkg::WWDPE_POWERUP;
                else if (sleepHit) next_state = wwdpe_pkg::WWDPE_SLEEP;
                else if (closedDone) next_state = wwdpe_pkg::WWDPE_OPEN;
            wwdpe_pkg::WWDPE_OPEN:
                if (goodClear) next_state = wwdpe_pkg::WWDPE_CLOSED;
                else if (sleepHit) next_state = wwdpe_pkg::WWDPE_SLEEP;
                else if (openLate) next_state = wwdpe_pkg::WWDPE_POWERUP;
            wwdpe_pkg::WWDPE_SLEEP:       if (clearEdge) next_state = wwdpe_pkg::WWDPE_POWERUP;
            default:                      next_state = wwdpe_pkg::WWDPE_MONITOR_LOW;
        endcase
        if (!monSync)
            next_state = wwdpe_pkg::WWDPE_MONITOR_LOW;
    end

    wire restartTicks = (next_state != state) || goodClear;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state     <= wwdpe_pkg::WWDPE_MONITOR_LOW;
            ticks     <= '0;
            idleTicks <= '0;
            goodCount <= 2'h0;
            enabled   <= 1'b0;
        end
        else
        begin
            state <= next_state;
            if (restartTicks)
                ticks <= '0;
            else if (tick)
                ticks <= ticks + 1'b1;
            // Idle count runs across watchdog resets so a halted host still reaches sleep
            if (clearEdge || !monSync)
                idleTicks <= '0;
            else if (tick && !sleepHit)
                idleTicks <= idleTicks + 1'b1;
            // Sleep may win over a late fault, so it drops the good count as well
            if (next_state == wwdpe_pkg::WWDPE_POWERUP || next_state == wwdpe_pkg::WWDPE_SLEEP
                || !monSync)
            begin
                goodCount <= 2'h0;
                enabled   <= 1'b0;
            end
            else if (goodClear && !enabled)
            begin
                goodCount <= goodCount + 2'h1;
                if (goodCount == 2'(wwdpe_pkg::GOOD_CLEARS_NEEDED - 1))
                    enabled <= 1'b1;
            end
        end
    end

    // ========================================
    // Outputs
    // ========================================
    // Reset pin is open drain: data low, enable high while holding reset
    wire holdReset = (state == wwdpe_pkg::WWDPE_MONITOR_LOW)
                     || (state == wwdpe_pkg::WWDPE_POWERUP);

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sysRstOe    <= 1'b1;
            enable_n    <= 1'b1;
            sleepActive <= 1'b0;
        end
        else
        begin
            sysRstOe    <= holdReset;
            enable_n    <= ~enabled;
            sleepActive <= (state == wwdpe_pkg::WWDPE_SLEEP);
        end
    end
    assign sysRstOut = 1'b0;

    // ========================================
    // Checks
    // ========================================
    AST_LOW_HOLDS_RESET: assert property (@(posedge core_clk) disable iff (rst)
        !monSync |-> ##2 sysRstOe)
        else $error("reset not held with monitor low");
    AST_EARLY_CLEAR: assert property (@(posedge core_clk) disable iff (rst)
        earlyClear && monSync |=> state == wwdpe_pkg::WWDPE_POWERUP ##1 sysRstOe)
        else $error("early clear did not reset");
    AST_LATE_CLEAR: assert property (@(posedge core_clk) disable iff (rst)
        state == wwdpe_pkg::WWDPE_OPEN && openLate && !clearEdge && monSync
        |=> state == wwdpe_pkg::WWDPE_POWERUP)
        else $error("late clear did not reset");
    AST_POWERUP_EXIT: assert property (@(posedge core_clk) disable iff (rst)
        state == wwdpe_pkg::WWDPE_POWERUP && monSync && powerupDone
        |=> state == wwdpe_pkg::WWDPE_CLOSED)
        else $error("power-up delay exit wrong");
    AST_WINDOW_SPLIT: assert property (@(posedge core_clk) disable iff (rst)
        $rose(state == wwdpe_pkg::WWDPE_OPEN) |-> $past(ticks) == (CLOSED_TICKS - 1))
        else $error("open window started at wrong time");
    AST_ENABLE_COUNT: assert property (@(posedge core_clk) disable iff (rst)
        $rose(enabled) |-> $past(goodCount) == 2'(wwdpe_pkg::GOOD_CLEARS_NEEDED - 1))
        else $error("enable without three good clears");
    AST_ENABLE_PIN: assert property (@(posedge core_clk) disable iff (rst)
        enabled |=> !enable_n)
        else $error("enable pin not low");
    AST_FAULT_CLEARS_ENABLE: assert property (@(posedge core_clk) disable iff (rst)
        wdtFault |=> !enabled && goodCount == 2'h0)
        else $error("fault did not clear enable");
    AST_ONE_EDGE: assert property (@(posedge core_clk) disable iff (rst)
        clearEdge |=> !clearEdge)
        else $error("clear counted twice");
    AST_SLEEP_ONLY_VARIANT: assert property (@(posedge core_clk) disable iff (rst)
        !HAS_SLEEP |-> state != wwdpe_pkg::WWDPE_SLEEP)
        else $error("sleep on non-sleep variant");

    COV_GOOD_CLEAR: cover property (@(posedge core_clk) disable iff (rst) goodClear);
    COV_ENABLED:    cover property (@(posedge core_clk) disable iff (rst) $fell(enable_n));
    COV_EARLY:      cover property (@(posedge core_clk) disable iff (rst) earlyClear);
    COV_SLEEP:      cover property (@(posedge core_clk) disable iff (rst) sleepActive);
endmodule

// ---- sim/wwdpe_host_model.sv ----
`timescale 1ns/1ps

// ========================================
// Host clear source
// ========================================
module wwdpe_host_model (
    input  wire logic core_clk,
    input  wire logic armed,
    input  int        gapCycles,
    output logic      wdtClearIn
);
    int cnt;

    // Pulse two cycles wide at the spacing the bench picks; the first pulse
    // comes early so it lands in the open window after a restart
    always @(negedge core_clk)
    begin
        if (!armed)
        begin
            cnt <= 4;
            wdtClearIn <= 1'b0;
        end
        else
        begin
            cnt <= (cnt >= gapCycles - 1) ? 0 : cnt + 1;
            wdtClearIn <= (cnt >= gapCycles - 2);
        end
    end
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ps

module testbench;
    localparam int DIV = 2;
    localparam int PUP = 4;
    localparam int PER = 12;
    logic core_clk, rst, monitorIn, armed;
    int   gap, bad_count, cmp_count, goodModel, n, k;
    wire  clr, rstOe, rstOut, enN, slp, rstOeB, rstOutB, enNB, slpB;
    // External pull-up on the open-drain reset pin
    wire  resetPinN = rstOe ? rstOut : 1'b1;

    // ========================================
    // Design and host
    // ========================================
    wwdpe_watchdog #(.OSC_DIV(DIV), .POWERUP_TICKS(PUP), .PERIOD_TICKS(PER)) dut (
        .core_clk(core_clk), .rst(rst), .monitor_in(monitorIn), .wdt_clear_in(clr),
        .sysRstOut(rstOut), .sysRstOe(rstOe), .enable_n(enN), .sleepActive(slp));
    wwdpe_watchdog #(.OSC_DIV(DIV), .POWERUP_TICKS(PUP), .PERIOD_TICKS(PER),
        .SLEEP_LIMIT(30), .SPLIT_33_67(1'b1), .HAS_SLEEP(1'b1)) dutB (
        .core_clk(core_clk), .rst(rst), .monitor_in(monitorIn), .wdt_clear_in(clr),
        .sysRstOut(rstOutB), .sysRstOe(rstOeB), .enable_n(enNB), .sleepActive(slpB));
    wwdpe_host_model host (.core_clk(core_clk), .armed(armed), .gapCycles(gap),
        .wdtClearIn(clr));

    // ========================================
    // Checks and helpers
    // ========================================
    task automatic chk_bit(input string nm, input logic e, input logic g);
        cmp_count++;
        if (g !== e)
        begin
            $display("Error %s expected %b seen %b", nm, e, g);
            bad_count++;
        end
    endtask

    task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
        cmp_count++;
        if (g < lo || g > hi)
        begin
            $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
            bad_count++;
        end
    endtask

    task automatic wait_oe(input logic want, input int lim, output int cnt);
        cnt = 0;
        while (rstOe !== want && cnt < lim)
        begin
            @(negedge core_clk);
            cnt++;
        end
    endtask

    // Model counts good clears; enable follows once enough have landed
    task automatic good_clear;
        int w;
        w = 0;
        while (clr !== 1'b1 && w < 40)
        begin
            @(negedge core_clk);
            w++;
        end
        repeat (6) @(negedge core_clk);
        goodModel++;
        chk_bit("enable_n", goodModel < wwdpe_pkg::GOOD_CLEARS_NEEDED, enN);
        chk_bit("enable_n split", goodModel < wwdpe_pkg::GOOD_CLEARS_NEEDED, enNB);
        chk_bit("sysRstOe", 1'b0, rstOe);
    endtask

    task automatic end_sim;
        $display("Checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Run needs well under 2000 cycles; 5000 means a hang
    initial
    begin
        #(5000 * 50);
        bad_count++;
        end_sim();
    end

    // ========================================
    // Scenarios
    // ========================================
    initial
    begin
        rst = 1'b1;
        monitorIn = 1'b0;
        armed = 1'b0;
        bad_count = 0;
        cmp_count = 0;
        goodModel = 0;
        void'($urandom(32'he4f8));
        // Any spacing from 18 to 21 cycles lands in the open part of both variants
        gap = 18 + $urandom_range(3, 0);
        repeat (6) @(negedge core_clk);
        rst <= 1'b0;
        repeat (10) @(negedge core_clk);
        chk_bit("reset while low", 1'b1, rstOe);
        chk_bit("enable at start", 1'b1, enN);
        monitorIn <= 1'b1;
        wait_oe(1'b0, 40, n);
        chk_rng("powerup cycles", PUP * DIV, PUP * DIV + 6, n);
        $display("test powerup done");
        armed <= 1'b1;
        repeat (3 + $urandom_range(2, 0)) good_clear();
        $display("test good clears done");
        @(negedge core_clk);
        armed <= 1'b0;
        @(negedge core_clk);
        gap <= 10;
        armed <= 1'b1;
        wait_oe(1'b1, 40, n);
        chk_rng("early clear reset", 1, 39, n);
        chk_bit("enable after fault", 1'b1, enN);
        chk_bit("split keeps running", 1'b0, rstOeB);
        armed <= 1'b0;
        goodModel = 0;
        $display("test early clear done");
        wait_oe(1'b0, 40, n);
        chk_rng("restart powerup", PUP * DIV - 2, PUP * DIV + 4, n);
        wait_oe(1'b1, 60, n);
        chk_rng("late reset", PER * DIV - 6, PER * DIV + 4, n);
        $display("test late clear done");
        k = 0;
        while (slpB !== 1'b1 && k < 400)
        begin
            @(negedge core_clk);
            k++;
        end
        chk_bit("sleep variant", 1'b1, slpB);
        chk_bit("no sleep variant", 1'b0, slp);
        $display("test sleep done");
        monitorIn <= 1'b0;
        repeat (5) @(negedge core_clk);
        chk_bit("reset monitor low", 1'b1, rstOe);
        chk_bit("reset pin level", 1'b0, resetPinN);
        chk_bit("split pin level", 1'b0, rstOeB ? rstOutB : 1'b1);
        chk_bit("enable monitor low", 1'b1, enN);
        $display("test monitor low done");
        end_sim();
    end
endmodule
